// ===== pkg/ccsr_consts.vh
/*
 * constants for the cpu cluster status register slice: offsets, field
 * positions, reset values. assumes inclusion by bare name from rtl files.
 */
`ifndef CCSR_CONSTS_VH
`define CCSR_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CCSR_OFS_MARGIN       12'h408
`define CCSR_OFS_EVCTL        12'h404
`define CCSR_OFS_STATUS_FIRST 12'h420
`define CCSR_OFS_STATUS_SECOND 12'h424
`define CCSR_OFS_IRQ_STATUS   12'h430
`define CCSR_OFS_IRQ_MASK     12'h434

// ----------------------------------------
// margin control fields
// ----------------------------------------
`define CCSR_MASK_SHIFT       16
`define CCSR_MARGIN_LSB_MASK  11'h7ff
`define CCSR_SENSE_BIT        10
`define CCSR_RAM_WM_HI        9
`define CCSR_RAM_WM_LO        8
`define CCSR_RAM_RM_HI        7
`define CCSR_RAM_RM_LO        5
`define CCSR_L2_WM_HI         4
`define CCSR_L2_WM_LO         3
`define CCSR_L2_RM_HI         2
`define CCSR_L2_RM_LO         0
`define CCSR_MARGIN_RESET     11'h021

// ----------------------------------------
// synchroniser reset image
// ----------------------------------------
// interrupt-wait standby bits 9:6 of the synchroniser chain start at one
`define CCSR_SYNC_RESET       26'h00003c0

// ----------------------------------------
// event control fields
// ----------------------------------------
`define CCSR_EV_CLEAR_BIT     5
`define CCSR_EV_DETECT_EN_BIT 6

// ----------------------------------------
// status first fields
// ----------------------------------------
`define CCSR_BOOST_HI         21
`define CCSR_BOOST_LO         15
`define CCSR_FLUSH_BIT        14
`define CCSR_MONACK_BIT       13
`define CCSR_DBGMODE_BIT      12
`define CCSR_TAPTOP_BIT       11
`define CCSR_EVEDGE_BIT       10

// ----------------------------------------
// status second fields
// ----------------------------------------
`define CCSR_L2IDLE_BIT       12

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define CCSR_IRQ_EVEDGE       0
`define CCSR_IRQ_FLUSH        1
`define CCSR_IRQ_MONACK       2
`define CCSR_IRQ_APPLY        3
`define CCSR_IRQ_W            4

`endif

// ===== rtl/ccsr_regs.v
/*
 * cpu cluster status register slice: margin control with per-bit write
 * mask, event control, two read-only status words, interrupt status/mask.
 * assumes a classic wishbone master on clk_i and cluster status levels
 * from another clock domain, so every status input is synchronised.
 */
// Contract
// - margin bit n changes only when the same write sets mask bit n+16
// - bit 10 is a write-only sense pulse margin; reads back zero
// - write margins 9:8,4:3 reset zero; read margins 7:5,2:0 reset one
// - boost state shown in seven bits 21:15 of status first
// - status first bit 14 reads one once l2 flush completed
// - status first bit 13 reads one on exclusive monitor clear ack
// - status first bit 12 one for jtag, zero for serial wire debug
// - status first bit 11 one while tap in its top four states
// - status first bits 3:0 show per-core coherency participation
// - status second bit 12 one only when cluster and l2 fully idle
// - status second bits 7:4 per-core interrupt-wait standby, set in reset
// - status second bits 3:0 per-core event-wait standby
// - writing one to event control bit 5 together with mask bit 21 clears the event-edge flag
// - with detect enable, a margin change stops cpu and applies margins
`include "ccsr_consts.vh"

module ccsr_regs (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [11:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire [6:0]  boost_state_view_i,
	input  wire        l2_flush_complete_i,
	input  wire        monitor_clear_ack_i,
	input  wire        debug_port_mode_flag_i,
	input  wire        tap_top_state_flag_i,
	input  wire        event_out_i,
	input  wire [3:0]  core_coherency_flags_i,
	input  wire [3:0]  core_interrupt_wait_standby_i,
	input  wire [3:0]  core_event_wait_standby_i,
	input  wire        l2_idle_standby_i,
	input  wire        apply_done_i,
	output reg         ram_sense_pulse_margin_o,
	output reg  [1:0]  ram_write_margin_o,
	output reg  [2:0]  ram_read_margin_o,
	output reg  [1:0]  l2_data_write_margin_o,
	output reg  [2:0]  l2_data_read_margin_o,
	output reg         cpu_stop_o,
	output reg         irq_o
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// every status level comes from the cluster's own clock domain, so each
	// bit passes two flops before any decode looks at it
	// limitation: a multi-bit field such as the boost state may show a mix
	// of old and new bits for one cycle while it changes; software that needs
	// a coherent value reads twice and compares
	localparam SW = 26;
	// interrupt-wait standby bits come up as one, matching the core's reset state
	localparam [SW-1:0] SYNC_RST = `CCSR_SYNC_RESET;

	wire [SW-1:0] raw_in;
	wire [SW-1:0] sync_b;

	assign raw_in[25:19] = boost_state_view_i;
	assign raw_in[18]    = l2_flush_complete_i;
	assign raw_in[17]    = monitor_clear_ack_i;
	assign raw_in[16]    = debug_port_mode_flag_i;
	assign raw_in[15]    = tap_top_state_flag_i;
	assign raw_in[14]    = event_out_i;
	assign raw_in[13:10] = core_coherency_flags_i;
	assign raw_in[9:6]   = core_interrupt_wait_standby_i;
	assign raw_in[5:2]   = core_event_wait_standby_i;
	assign raw_in[1]     = l2_idle_standby_i;
	assign raw_in[0]     = apply_done_i;

	// one two-flop chain per bit; only the second flop is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < SW; gi = gi + 1) begin : g_sync
			reg stage_a;
			reg stage_b;
			always @(posedge clk_i) begin
				if (rst_i) begin
					stage_a <= SYNC_RST[gi];
					stage_b <= SYNC_RST[gi];
				end else begin
					stage_a <= raw_in[gi];
					stage_b <= stage_a;
				end
			end
			assign sync_b[gi] = stage_b;
		end
	endgenerate

	wire [6:0] boost_s   = sync_b[25:19];
	wire       flush_s   = sync_b[18];
	wire       monack_s  = sync_b[17];
	wire       dbgmode_s = sync_b[16];
	wire       taptop_s  = sync_b[15];
	wire       evout_s   = sync_b[14];
	wire [3:0] coh_s     = sync_b[13:10];
	wire [3:0] wfi_s     = sync_b[9:6];
	wire [3:0] wfe_s     = sync_b[5:2];
	wire       l2idle_s  = sync_b[1];
	wire       apply_s   = sync_b[0];

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// address match shared by every write strobe
	function ccsr_hit;
		input [11:0] adr;
		input [11:0] ofs;
		begin
			ccsr_hit = (adr == ofs);
		end
	endfunction

	// ack masks the request so a master that holds stb one cycle too long
	// cannot have its write applied twice
	wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// partial-lane writes are acked but dropped: margin and event fields span lanes
	wire wr       = req & wb_we_i & (&wb_sel_i);
	wire wr_margin = wr & ccsr_hit(wb_adr_i, `CCSR_OFS_MARGIN);
	wire wr_evctl  = wr & ccsr_hit(wb_adr_i, `CCSR_OFS_EVCTL);
	wire wr_istat  = wr & ccsr_hit(wb_adr_i, `CCSR_OFS_IRQ_STATUS);
	wire wr_imask  = wr & ccsr_hit(wb_adr_i, `CCSR_OFS_IRQ_MASK);

	// apply masked write: lower bit n taken only where mask bit n+16 set
	function [10:0] ccsr_masked;
		input [10:0] old_v;
		input [31:0] wd;
		begin
			ccsr_masked = (old_v & ~wd[26:16]) | (wd[10:0] & wd[26:16]);
		end
	endfunction

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	reg  [10:0] margin;
	reg  [1:0]  evctl;
	reg         ev_edge;
	reg         ev_prev;
	reg  [3:0]  ista;
	reg  [3:0]  imask;
	reg         stop_pend;
	reg         flush_prev;
	reg         monack_prev;

	wire [10:0] next_margin = ccsr_masked(margin, wb_dat_i) & `CCSR_MARGIN_LSB_MASK;
	wire        margin_chg  = wr_margin & (next_margin != margin);
	wire        ev_rise     = evout_s & ~ev_prev;
	wire        ev_clr      = wr_evctl & wb_dat_i[`CCSR_EV_CLEAR_BIT] & wb_dat_i[`CCSR_EV_CLEAR_BIT + 16];
	wire [3:0]  events      = {stop_pend & apply_s, monack_s & ~monack_prev, flush_s & ~flush_prev, ev_rise};

	always @(posedge clk_i) begin
		if (rst_i) begin
			margin      <= `CCSR_MARGIN_RESET;
			evctl       <= 2'h0;
			ev_edge     <= 1'b0;
			ev_prev     <= 1'b0;
			ista        <= 4'h0;
			imask       <= 4'h0;
			stop_pend   <= 1'b0;
			flush_prev  <= 1'b0;
			monack_prev <= 1'b0;
		end else begin
			ev_prev     <= evout_s;
			flush_prev  <= flush_s;
			monack_prev <= monack_s;
			if (wr_margin)
				margin <= next_margin;
			// control bit 6 is kept; clear bit 5 acts as a strobe only
			if (wr_evctl && wb_dat_i[`CCSR_EV_DETECT_EN_BIT + 16])
				evctl[1] <= wb_dat_i[`CCSR_EV_DETECT_EN_BIT];
			evctl[0] <= 1'b0;
			// a rising edge in the clearing cycle wins
			if (ev_rise)
				ev_edge <= 1'b1;
			else if (ev_clr)
				ev_edge <= 1'b0;
			if (wr_imask)
				imask <= wb_dat_i[3:0];
			ista <= events | (ista & ~(wr_istat ? wb_dat_i[3:0] : 4'h0));
			// cpu held stopped until the cluster reports new margins taken;
			// a write that leaves every field unchanged does not stop it, so
			// software may rewrite the same margins without a stall
			// hazard: the done level is seen two cycles late, so the cluster
			// must keep it up until the stop falls
			if (margin_chg && evctl[1])
				stop_pend <= 1'b1;
			else if (apply_s)
				stop_pend <= 1'b0;
		end
	end

	// ----------------------------------------
	// outputs toward the cluster memories, the cpu stop and the interrupt line
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			ram_sense_pulse_margin_o <= 1'b0;
			ram_write_margin_o       <= 2'h0;
			ram_read_margin_o        <= 3'h1;
			l2_data_write_margin_o   <= 2'h0;
			l2_data_read_margin_o    <= 3'h1;
			cpu_stop_o               <= 1'b0;
			irq_o                    <= 1'b0;
		end else begin
			ram_sense_pulse_margin_o <= margin[`CCSR_SENSE_BIT];
			ram_write_margin_o       <= margin[`CCSR_RAM_WM_HI:`CCSR_RAM_WM_LO];
			ram_read_margin_o        <= margin[`CCSR_RAM_RM_HI:`CCSR_RAM_RM_LO];
			l2_data_write_margin_o   <= margin[`CCSR_L2_WM_HI:`CCSR_L2_WM_LO];
			l2_data_read_margin_o    <= margin[`CCSR_L2_RM_HI:`CCSR_L2_RM_LO];
			cpu_stop_o               <= stop_pend | (margin_chg & evctl[1]);
			irq_o                    <= |(ista & imask);
		end
	end

	// ----------------------------------------
	// read mux and acknowledge
	// ----------------------------------------
	reg [31:0] rd;
	always @* begin
		rd = 32'h0;
		case (wb_adr_i)
		`CCSR_OFS_MARGIN: begin
			rd[9:0] = margin[9:0];
		end
		`CCSR_OFS_EVCTL: begin
			rd[`CCSR_EV_DETECT_EN_BIT] = evctl[1];
		end
		`CCSR_OFS_STATUS_FIRST: begin
			rd[`CCSR_BOOST_HI:`CCSR_BOOST_LO] = boost_s;
			rd[`CCSR_FLUSH_BIT]   = flush_s;
			rd[`CCSR_MONACK_BIT]  = monack_s;
			rd[`CCSR_DBGMODE_BIT] = dbgmode_s;
			rd[`CCSR_TAPTOP_BIT]  = taptop_s;
			rd[`CCSR_EVEDGE_BIT]  = ev_edge;
			rd[3:0]               = coh_s;
		end
		`CCSR_OFS_STATUS_SECOND: begin
			// power controller relies on these before cutting power
			rd[`CCSR_L2IDLE_BIT] = l2idle_s;
			rd[7:4]              = wfi_s;
			rd[3:0]              = wfe_s;
		end
		`CCSR_OFS_IRQ_STATUS: begin
			rd[3:0] = ista;
		end
		`CCSR_OFS_IRQ_MASK: begin
			rd[3:0] = imask;
		end
		default: begin
			rd = 32'h0;
		end
		endcase
	end

	// one-cycle answer; unmapped reads give zero, writes there are dropped
	// read data is zero outside the ack cycle so a bus that ors its slaves'
	// data together needs no further gating
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd : 32'h0;
		end
	end

endmodule

// ===== tb/ccsr_regs_asserts.sv
/* ccsr_regs checker: bus timing, margin writes, stop, reserved bits.
   assumes a bind onto ccsr_regs. */
module ccsr_regs_asserts (
	input logic        clk_i,
	input logic        rst_i,
	input logic        wb_cyc_i,
	input logic        wb_stb_i,
	input logic        wb_we_i,
	input logic [11:0] wb_adr_i,
	input logic [3:0]  wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic [31:0] wb_dat_o,
	input logic        wb_ack_o,
	input logic        apply_done_i,
	input logic        ram_sense_pulse_margin_o,
	input logic [1:0]  ram_write_margin_o,
	input logic [2:0]  ram_read_margin_o,
	input logic [1:0]  l2_data_write_margin_o,
	input logic [2:0]  l2_data_read_margin_o,
	input logic        cpu_stop_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------
	// properties
	// ----------
	wire        tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        mw = tk && wb_we_i && wb_adr_i == 12'h408 && wb_sel_i == 4'hf;
	wire [10:0] wd = wb_dat_i[10:0];
	wire [10:0] mg = {ram_sense_pulse_margin_o, ram_write_margin_o, ram_read_margin_o,
		l2_data_write_margin_o, l2_data_read_margin_o};
	// unmapped words read all zero, so the default masks every bit
	wire [31:0] rm = wb_adr_i == 12'h408 ? 32'hfffffc00 : wb_adr_i == 12'h420 ? 32'hffc003f0 :
		wb_adr_i == 12'h424 ? 32'hffffef00 : wb_adr_i == 12'h404 ? 32'hffffffbf :
		(wb_adr_i == 12'h430 || wb_adr_i == 12'h434) ? 32'hfffffff0 : 32'hffffffff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack1; tk |=> wb_ack_o; endproperty
	property p_ackp; wb_ack_o |=> !wb_ack_o; endproperty
	property p_dz; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	property p_mrst; $fell(rst_i) |-> mg == 11'h021; endproperty
	property p_mhold; mw && wb_dat_i[26:16] == 11'h0 |-> ##3 $stable(mg); endproperty
	property p_mset; mw && wb_dat_i[26:16] == 11'h7ff |-> ##3 mg == $past(wd, 3); endproperty
	property p_rsv; wb_ack_o && !wb_we_i |-> (wb_dat_o & rm) == 32'h0; endproperty
	property p_srise; $rose(cpu_stop_o) |-> $past(tk && wb_we_i); endproperty
	// the done level crosses two flops before it may end a stop
	property p_sfall;
		$fell(cpu_stop_o) |-> $past(apply_done_i, 2) || $past(apply_done_i, 3) || $past(apply_done_i, 4);
	endproperty
	a_ack1: assert property (p_ack1) else $error("no ack");
	a_ackp: assert property (p_ackp) else $error("ack too long");
	a_dz: assert property (p_dz) else $error("data without ack");
	a_mrst: assert property (p_mrst) else $error("margin reset");
	a_mhold: assert property (p_mhold) else $error("masked bits moved");
	a_mset: assert property (p_mset) else $error("margin not taken");
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	a_srise: assert property (p_srise) else $error("stop without write");
	a_sfall: assert property (p_sfall) else $error("stop ended early");
	c_mset: cover property (mw && wb_dat_i[26:16] != 11'h0);
	c_stop: cover property ($rose(cpu_stop_o));
	c_rd: cover property (wb_ack_o && !wb_we_i && wb_adr_i == 12'h424);
endmodule

bind ccsr_regs ccsr_regs_asserts chk_u (.*);

// ===== tb/ccsr_cluster_model.sv
/* cluster and power controller model feeding the status inputs.
   assumes ctl_i from the bench, stop from the register slice. */
module ccsr_cluster_model (
	input  logic        clk_i,
	input  logic        rst_i,
	input  logic        cpu_stop_i,
	input  logic        slow_i,
	input  logic [24:0] ctl_i,
	output logic [23:0] st_o,
	output logic        l2_idle_o,
	output logic        apply_done_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt;
	assign st_o = rst_i ? {ctl_i[23:4], 4'hf} : ctl_i[23:0];
	assign l2_idle_o = &st_o[3:0] & ctl_i[24];
	// power is never removed here, so standby bits are always honoured
	always @(posedge clk_i) begin
		if (rst_i || !cpu_stop_i)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
	end
	assign apply_done_o = cpu_stop_i && cnt >= (slow_i ? 4'hc : 4'h1);
endmodule

// ===== tb/ccsr_regs_tb.sv
/* ccsr_regs testbench: wishbone accesses checked against expected words.
   assumes ccsr_cluster_model drives the status inputs. */
module ccsr_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slow = 0, ack, l2i, apd, sns, stop, irq;
	logic [11:0] adr = 0;
	logic [3:0]  sel = 0;
	logic [31:0] dat = 0, q, dat_o;
	logic [24:0] ctl = 0;
	logic [23:0] st;
	logic [1:0]  rw, lw;
	logic [2:0]  rr, lr;
	logic [24:0] pat [4] = '{25'h1ffefff, 25'h0b4a5a3, 25'h100000f, 25'h000000f};
	int bad_count = 0, checked = 0;
	always #12.5 clk_i = ~clk_i;
	ccsr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .boost_state_view_i(st[23:17]),
		.l2_flush_complete_i(st[16]), .monitor_clear_ack_i(st[15]), .debug_port_mode_flag_i(st[14]),
		.tap_top_state_flag_i(st[13]), .event_out_i(st[12]), .core_coherency_flags_i(st[11:8]),
		.core_event_wait_standby_i(st[7:4]), .core_interrupt_wait_standby_i(st[3:0]), .l2_idle_standby_i(l2i),
		.apply_done_i(apd), .ram_sense_pulse_margin_o(sns), .ram_write_margin_o(rw), .ram_read_margin_o(rr),
		.l2_data_write_margin_o(lw), .l2_data_read_margin_o(lr), .cpu_stop_o(stop), .irq_o(irq));
	ccsr_cluster_model part_u (.clk_i(clk_i), .rst_i(rst_i), .cpu_stop_i(stop), .slow_i(slow), .ctl_i(ctl),
		.st_o(st), .l2_idle_o(l2i), .apply_done_o(apd));
	// ----------
	// tasks
	// ----------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		q = dat_o;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(a, 32'h0, 1'b0, 4'hf);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(a, d, 1'b1, 4'hf);
	endtask
	task automatic setc(input logic [24:0] c);
		ctl <= c;
		repeat (5) @(posedge clk_i);
	endtask
	function automatic logic [31:0] sf(input logic [24:0] c);
		return {10'h0, c[23:13], 7'h0, c[11:8]};
	endfunction
	function automatic logic [31:0] ss(input logic [24:0] c);
		return {19'h0, &c[3:0] & c[24], 4'h0, c[3:0], c[7:4]};
	endfunction
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		rd(12'h408, 32'h021);
		wr(12'h408, 32'h0000_07ff);
		rd(12'h408, 32'h021);
		wr(12'h408, 32'h00e0_00e0);
		wr(12'h408, 32'hf800_f800);
		bus(12'h408, 32'h07ff_0000, 1'b1, 4'h3);
		rd(12'h408, 32'h0e1);
		wr(12'h408, 32'h0400_0400);
		@(posedge clk_i);
		chk("sense out", 32'h1, {31'h0, sns});
		rd(12'h408, 32'h0e1);
		rd(12'h500, 32'h0);
		for (int i = 0; i < 4; i++) begin
			setc(pat[i]);
			rd(12'h420, sf(pat[i]));
			rd(12'h424, ss(pat[i]));
		end
		wr(12'h430, 32'hffff_ffff);
		wr(12'h434, 32'h1);
		setc(25'h1000);
		rd(12'h420, 32'h400);
		chk("irq", 32'h1, {31'h0, irq});
		setc(25'h0);
		rd(12'h420, 32'h400);
		wr(12'h434, 32'h0);
		@(posedge clk_i);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(12'h404, 32'h0020_0020);
		rd(12'h420, 32'h0);
		rd(12'h430, 32'h1);
		wr(12'h430, 32'h1);
		rd(12'h430, 32'h0);
		wr(12'h404, 32'h0040_0040);
		rd(12'h404, 32'h40);
		// slow then prompt acknowledge of the new margins
		for (int i = 0; i < 2; i++) begin
			slow <= i == 0;
			wr(12'h408, i ? 32'h07ff_0021 : 32'h07ff_00e3);
			@(posedge clk_i);
			chk("stop", 32'h1, {31'h0, stop});
			repeat (40) if (stop === 1'b1) @(posedge clk_i);
			chk("stop end", 32'h0, {31'h0, stop});
			rd(12'h430, 32'h8);
			wr(12'h430, 32'hf);
			rd(12'h408, i ? 32'h021 : 32'h0e3);
		end
		wrap_up();
	end
endmodule
